// ===== common/msc_pkg.sv
// constants and types shared by the monitor sequencer control block
package msc_pkg;
    localparam int MSC_NUM_CHAN = 4;
    // output steps per sequence: bus voltage and shunt current per channel
    localparam int MSC_STEP_W = 4;
    localparam logic [3:0] MSC_STEP_FIRST = 4'h0;
    localparam logic [3:0] MSC_STEP_LAST = 4'h7;
    localparam int MSC_NUM_STEP = 8;
    localparam int MSC_CLK_MHZ = 250;
    localparam int MSC_TIMEOUT_NS = 45000;
    localparam int MSC_TIMEOUT_CYC = (MSC_TIMEOUT_NS * MSC_CLK_MHZ) / 1000;
    localparam int MSC_CNT_W = 16;
    localparam logic [3:0] MSC_ENABLE_RESET = 4'h0;

    typedef enum logic [1:0] {
        MSC_MODE_FULL = 2'b00,
        MSC_MODE_LIMITED = 2'b01,
        MSC_MODE_STANDBY = 2'b10
    } msc_mode_t;
endpackage : msc_pkg

// ===== verilog/msc_step_pick.sv
// picks the next enabled output step after the current one, wrapping round
`timescale 1ns/10ps
module msc_step_pick
    import msc_pkg::*;
(
    input wire logic [3:0] cur_step,
    input wire logic [3:0] chan_enable,
    input wire logic from_start,
    output logic [3:0] next_step,
    output logic any_enabled
);
    logic [3:0] cand;
    logic found;
    always_comb begin
        next_step = MSC_STEP_FIRST;
        found = 1'b0;
        cand = MSC_STEP_FIRST;
        any_enabled = |chan_enable;
        // two steps per channel; scan ahead in order, first hit wins
        for (int i = 0; i < MSC_NUM_STEP; i++) begin
            if (from_start) begin
                cand = 4'(i);
            end else begin
                cand = 4'((32'(cur_step) + 32'(i) + 1) % MSC_NUM_STEP);
            end
            if (!found && chan_enable[cand[2:1]]) begin
                next_step = cand;
                found = 1'b1;
            end
        end
    end
endmodule : msc_step_pick

// ===== verilog/msc_seq_ctrl.sv
// bus-valid flag, enable-pin mode decode and channel sequence control
`timescale 1ns/10ps
module msc_seq_ctrl
    import msc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic supply_ok,
    input wire logic enable_in_n,
    input wire logic enable_float,
    input wire logic override_pin,
    input wire logic [3:0] bus_voltage_input,
    input wire logic [3:0] channel_enable_field,
    input wire logic timeout_enable,
    input wire logic channel_step_input,
    output logic bus_valid_flag_o,
    output logic bus_valid_flag_oe,
    output logic [3:0] step_index,
    output logic step_valid,
    output logic diff_out_en,
    output logic bandgap_output_en,
    output logic [1:0] mode
);
    // all sequencing state; the reset synchroniser lives apart
    typedef struct packed {
        msc_mode_t mode;
        logic en_prev;
        logic sel_prev;
        logic started;
        logic [3:0] step;
        logic step_ok;
        logic [MSC_CNT_W-1:0] idle_cnt;
        logic flag_oe;
        logic diff_en;
        logic bg_en;
    } msc_state_t;

    // 45 us in clock cycles; the counter width leaves headroom
    localparam logic [MSC_CNT_W-1:0] IDLE_LIMIT = MSC_CNT_W'(MSC_TIMEOUT_CYC);

    msc_state_t state_q;
    msc_state_t state_d;
    // the synchroniser has its own reset, so it sits outside the state record
    logic [1:0] rst_sync_q;
    logic rst_n_int;
    logic [3:0] pick_step;
    logic pick_any;
    logic [MSC_NUM_CHAN-1:0] chan_ok;
    logic all_valid;
    logic flag_pull;
    logic sel_edge;
    logic en_toggle;
    logic idle_expired;
    msc_mode_t mode_nxt;

    // assert at once, release only after two clean edges
    assign rst_n_int = rst_sync_q[1];
    // both directions of the select line count as a step
    assign sel_edge = channel_step_input != state_q.sel_prev;
    // any change of the pin level, either way, restarts the sequence
    assign en_toggle = enable_in_n != state_q.en_prev;
    // limit minus one: the restart then lands on the limit-th idle edge
    assign idle_expired = state_q.idle_cnt >= IDLE_LIMIT - 1'b1;

    // a sequence that has not started yet takes the first enabled step
    msc_step_pick u_pick (
        .cur_step(state_q.step),
        .chan_enable(channel_enable_field),
        .from_start(!state_q.started),
        .next_step(pick_step),
        .any_enabled(pick_any)
    );

    // disabled channels read as valid so they never hold the flag down
    for (genvar c = 0; c < MSC_NUM_CHAN; c++) begin : g_chan
        assign chan_ok[c] = !channel_enable_field[c] || bus_voltage_input[c];
    end
    assign all_valid = &chan_ok;

    // open drain: oe high pulls the pin low, oe low leaves it to the pull-up
    always_comb begin
        if (!override_pin) begin
            flag_pull = 1'b0;
        // supply absent: the flag is pulled low, and only the override pin can release it
        end else if (!supply_ok) begin
            flag_pull = 1'b1;
        end else if (mode_nxt == MSC_MODE_STANDBY) begin
            flag_pull = 1'b1;
        // limited mode keeps the comparators live, so it follows the inputs
        end else begin
            flag_pull = !all_valid;
        end
    end

    // float overrides pin level: a floating pin reads arbitrarily
    always_comb begin
        if (enable_float) begin
            mode_nxt = MSC_MODE_LIMITED;
        end else if (enable_in_n) begin
            mode_nxt = MSC_MODE_STANDBY;
        end else begin
            mode_nxt = MSC_MODE_FULL;
        end
    end

    // select edges advance; timeouts, toggles and idle modes restart
    always_comb begin
        state_d = state_q;
        state_d.mode = mode_nxt;
        state_d.en_prev = enable_in_n;
        // last sample of the line, for the edge detect
        state_d.sel_prev = channel_step_input;
        // bandgap stays up in limited mode as the comparator reference
        state_d.bg_en = (state_d.mode != MSC_MODE_STANDBY) && supply_ok;
        // driver turns on a cycle after the step, so the first sample is settled
        state_d.diff_en = (state_d.mode == MSC_MODE_FULL) && supply_ok
            && state_q.step_ok;

        case (state_q.mode)
            MSC_MODE_FULL: begin
                if (sel_edge) begin
                    state_d.idle_cnt = '0;
                    state_d.started = 1'b1;
                    state_d.step = pick_step;
                    // no enabled channel leaves the step invalid
                    state_d.step_ok = pick_any;
                end else if (timeout_enable && state_q.started) begin
                    // counts only after the first step, so an idle line restarts once
                    if (idle_expired) begin
                        state_d.started = 1'b0;
                        state_d.step = MSC_STEP_FIRST;
                        state_d.step_ok = 1'b0;
                        state_d.idle_cnt = '0;
                    end else begin
                        state_d.idle_cnt = state_q.idle_cnt + 1'b1;
                    end
                end else begin
                    // without timeout the step only wraps by stepping
                    state_d.idle_cnt = '0;
                end
            end
            MSC_MODE_LIMITED, MSC_MODE_STANDBY: begin
                // select edges are dropped; the edge detector keeps tracking the line
                state_d.started = 1'b0;
                state_d.step = MSC_STEP_FIRST;
                state_d.step_ok = 1'b0;
                state_d.idle_cnt = '0;
            end
            default: begin
                // unused code: fall back to the idle mode
                state_d.mode = MSC_MODE_STANDBY;
            end
        endcase

        // after the case, so a toggle beats a select edge in the same cycle
        if (en_toggle) begin
            state_d.started = 1'b0;
            state_d.step = MSC_STEP_FIRST;
            state_d.step_ok = 1'b0;
            state_d.idle_cnt = '0;
        end

        state_d.flag_oe = flag_pull;
    end

    // only the second flop is read; the first may still be settling
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // the state waits for the synchronised release of reset
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            state_q.mode <= MSC_MODE_STANDBY;
            // reset to the standby level: a low pin after reset reads as a toggle
            state_q.en_prev <= 1'b1;
            state_q.sel_prev <= 1'b0;
            state_q.started <= 1'b0;
            state_q.step <= MSC_STEP_FIRST;
            state_q.step_ok <= 1'b0;
            state_q.idle_cnt <= '0;
            state_q.flag_oe <= 1'b0;
            state_q.diff_en <= 1'b0;
            state_q.bg_en <= 1'b0;
        end else begin
            state_q.mode <= state_d.mode;
            state_q.en_prev <= state_d.en_prev;
            state_q.sel_prev <= state_d.sel_prev;
            state_q.started <= state_d.started;
            state_q.step <= state_d.step;
            state_q.step_ok <= state_d.step_ok;
            state_q.idle_cnt <= state_d.idle_cnt;
            state_q.flag_oe <= state_d.flag_oe;
            state_q.diff_en <= state_d.diff_en;
            state_q.bg_en <= state_d.bg_en;
        end
    end

    // data half of the open-drain pair is tied low; oe alone moves the pin
    assign bus_valid_flag_o = 1'b0;
    assign bus_valid_flag_oe = state_q.flag_oe;
    assign step_index = state_q.step;
    assign step_valid = state_q.step_ok;
    assign diff_out_en = state_q.diff_en;
    assign bandgap_output_en = state_q.bg_en;
    assign mode = state_q.mode;
endmodule : msc_seq_ctrl

// ===== bench/msc_host_model.sv
// host model stepping the channel select line
`timescale 1ns/10ps
module msc_host_model (
    input wire logic clk,
    input wire logic run,
    input wire logic slow,
    output logic sel
);
    // slow host holds each level two cycles
    logic ph = 1'b0;
    initial sel = 1'b0;
    always @(posedge clk) begin
        ph <= !ph;
        if (run && (ph || !slow)) sel <= !sel;
    end
endmodule : msc_host_model

// ===== bench/msc_seq_ctrl_properties.sv
// port assertions for the monitor sequencer control block
`timescale 1ns/10ps
module msc_seq_ctrl_chk
    import msc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic supply_ok,
    input wire logic enable_in_n,
    input wire logic enable_float,
    input wire logic override_pin,
    input wire logic [3:0] bus_voltage_input,
    input wire logic [3:0] channel_enable_field,
    input wire logic channel_step_input,
    input wire logic bus_valid_flag_oe,
    input wire logic [3:0] step_index,
    input wire logic step_valid,
    input wire logic diff_out_en,
    input wire logic [1:0] mode
);
    // outputs lag the two-flop reset release
    logic [3:0] up_q;
    wire up = up_q[3];
    wire sb = enable_in_n && !enable_float;
    wire arm = up && override_pin && supply_ok;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            up_q <= 4'h0;
        end else begin
            up_q <= {up_q[2:0], 1'b1};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence quiet2;
        up && mode != MSC_MODE_FULL ##1 mode != MSC_MODE_FULL;
    endsequence
    sequence full_step;
        up && mode == MSC_MODE_FULL && !sb && !enable_float && $stable(enable_in_n) ##0
            step_valid && $changed(channel_step_input) && channel_enable_field == 4'hf;
    endsequence
    release_flag_a: assert property (up && !override_pin |=> !bus_valid_flag_oe)
        else $error("flag held");
    nosupply_low_a: assert property (up && override_pin && !supply_ok |=> bus_valid_flag_oe)
        else $error("flag open");
    standby_low_a: assert property (arm && sb |=> bus_valid_flag_oe)
        else $error("flag open");
    bus_low_a: assert property (
        arm && !sb |=> bus_valid_flag_oe == $past(|(channel_enable_field & ~bus_voltage_input)))
        else $error("flag wrong");
    mode_decode_a: assert property (up |=> mode ==
        $past(enable_float ? MSC_MODE_LIMITED : sb ? MSC_MODE_STANDBY : MSC_MODE_FULL))
        else $error("mode wrong");
    quiet_out_a: assert property (
        quiet2 |-> !diff_out_en && !step_valid && step_index == MSC_STEP_FIRST)
        else $error("not idle");
    enable_restart_a: assert property (
        up && $changed(enable_in_n) |=> !step_valid && step_index == MSC_STEP_FIRST)
        else $error("no restart");
    step_advance_a: assert property (full_step |=> step_index ==
        ($past(step_index) == MSC_STEP_LAST ? MSC_STEP_FIRST : $past(step_index) + 4'h1))
        else $error("bad step");
endmodule : msc_seq_ctrl_chk
bind msc_seq_ctrl msc_seq_ctrl_chk msc_seq_ctrl_chk_i (.clk, .reset_n, .supply_ok, .enable_in_n,
    .enable_float, .override_pin, .bus_voltage_input, .channel_enable_field, .channel_step_input,
    .bus_valid_flag_oe, .step_index, .step_valid, .diff_out_en, .mode);

// ===== bench/tb_top.sv
// self-checking bench for the monitor sequencer control block
`timescale 1ns/10ps
module tb_top;
    import msc_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, sup = 1'b1, en_n = 1'b0, fl = 1'b0, ov = 1'b1;
    logic to_en = 1'b1, run = 1'b0, slow = 1'b0, sel, flo, oe, sv, de, bg;
    logic [3:0] bv = 4'hf, fe = 4'hf, si;
    logic [1:0] md;
    int err_total = 0, num_checks = 0;
    // supply, enable, float, override, bus inputs, enables, expected flag
    logic [15:0] fc [9] = '{16'h1ff1, 16'h0ff0, 16'hdff1, 16'hcff0, 16'h9ef1, 16'h9ee0,
        16'hb7f1, 16'ha0f0, 16'h9ff0};
    always #2 clk = ~clk;
    msc_host_model msc_host_model_i (.clk, .run, .slow, .sel);
    msc_seq_ctrl msc_seq_ctrl_i (.clk, .reset_n, .supply_ok(sup), .enable_in_n(en_n),
        .enable_float(fl), .override_pin(ov), .bus_voltage_input(bv), .channel_enable_field(fe),
        .timeout_enable(to_en), .channel_step_input(sel), .bus_valid_flag_o(flo),
        .bus_valid_flag_oe(oe), .step_index(si), .step_valid(sv), .diff_out_en(de),
        .bandgap_output_en(bg), .mode(md));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic next_step(input logic [4:0] e);
        logic [4:0] old;
        int i;
        old = {sv, si};
        for (i = 0; i < 40 && {sv, si} === old; i++) cyc(1);
        if (i == 40) begin
            err_total++;
            complete_run();
        end else begin
            chk("step", e, {sv, si});
        end
    endtask : next_step
    task automatic restart(input logic [3:0] f, input logic s);
        @(posedge clk);
        {run, slow, fe, en_n} <= {1'b0, s, f, 1'b1};
        @(posedge clk);
        en_n <= 1'b0;
        cyc(3);
        chk("restart", 5'h00, {sv, si});
        @(posedge clk);
        run <= 1'b1;
    endtask : restart
    task automatic t_seq;
        foreach (fc[k]) begin
            @(posedge clk);
            {sup, en_n, fl, ov, bv, fe} <= fc[k][15:4];
            cyc(3);
            chk("flag", {4'h0, fc[k][0]}, {4'h0, oe});
            chk("flag data", 5'h00, {4'h0, flo});
        end
        restart(4'hf, 1'b0);
        for (int i = 0; i <= MSC_NUM_STEP; i++) next_step({1'b1, 4'(i % MSC_NUM_STEP)});
        restart(4'h5, 1'b1);
        for (int i = 0; i < 5; i++) next_step({1'b1, 4'(i % 4 / 2 * 4 + i % 2)});
        $display("flag and sequence test done");
    endtask : t_seq
    task automatic t_timeout;
        logic [4:0] s;
        @(posedge clk);
        run <= 1'b0;
        cyc(MSC_TIMEOUT_CYC + 8);
        chk("timeout", 5'h00, {sv, si});
        @(posedge clk);
        run <= 1'b1;
        next_step(5'h10);
        @(posedge clk);
        {run, to_en} <= 2'b00;
        cyc(4);
        s = {sv, si};
        cyc(MSC_TIMEOUT_CYC + 8);
        chk("no timeout", s, {sv, si});
        $display("timeout test done");
    endtask : t_timeout
    task automatic t_mode;
        @(posedge clk);
        {run, to_en, fl} <= 3'b111;
        cyc(4);
        chk("limited", 5'h0c, {md, bg, de, sv});
        @(posedge clk);
        {fl, en_n} <= 2'b01;
        cyc(4);
        chk("standby", 5'h10, {md, bg, de, sv});
        @(posedge clk);
        en_n <= 1'b0;
        cyc(8);
        chk("full", 5'h07, {md, bg, de, sv});
        $display("mode test done");
    endtask : t_mode
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        cyc(3);
        t_seq();
        t_timeout();
        t_mode();
        complete_run();
    end
endmodule : tb_top
